// ===== ais_defs.vh
// Constants for the analog input status link block
`ifndef AIS_DEFS_VH
`define AIS_DEFS_VH
// Link count and status link positions
`define AIS_NUM_CH 8
`define AIS_NUM_LINKS 10
`define AIS_LINK_COND 8
`define AIS_LINK_FAULT 9
// Per-channel flag positions inside a nibble
`define AIS_BIT_OPEN 0
`define AIS_BIT_OVER 1
`define AIS_BIT_UNDER 2
`define AIS_BIT_BADCFG 3
`define AIS_FLAGS_PER_CH 4
// Card fault bit positions
`define AIS_FLT_ADC 0
`define AIS_FLT_COMMS 1
`define AIS_FLT_WDOG 2
`define AIS_FLT_CAL 3
`define AIS_FLT_FW 4
`define AIS_FLT_USED 5
// Range codes
`define AIS_RANGE_W 3
`define AIS_RANGE_0_20MA 3'h0
`define AIS_RANGE_4_20MA 3'h1
`define AIS_RANGE_RTD3 3'h2
`define AIS_RANGE_RTD4 3'h3
// Current thresholds in microamps for the 4-20 mA wire break test
`define AIS_OPEN_SET_UA 32'h000007d0
`define AIS_OPEN_CLR_UA 32'h00000bb8
// Link period in microseconds
`define AIS_LINK_PERIOD_US 2000
`define AIS_CLK_MHZ 200
// Zero words
`define AIS_ZERO32 32'h00000000
`endif

// ===== ais_status_links.v
// Analog input status and data link formation
// Functional notes
// - Channels 0..7 results go out on links one through eight in order.
// - Condition word on link nine, card fault word on link ten.
// - Each channel link carries a single-precision float measurement.
// - Both status links are 32-bit words with one flag per bit.
// - A channel result updates when that channel finishes an acquisition.
// - All links are sent to the host every 2 ms, continuously.
// - Condition word holds four status bits per channel.
// - Channel n uses bits 4n..4n+3: open, over, under, bad setup.
// - Wire break flag never sets in the 0-20 mA range.
// - In 4-20 mA range wire break sets below 2 mA.
// - Wire break clears above 3 mA, giving hysteresis, or when the channel is disabled or leaves the 4-20 mA range.
// - Over range flag follows value at or above range high limit.
// - Below range flag follows value at or below range low limit.
// - Invalid setup flag follows invalid channel configuration.
// - Invalid channel reports 0.0 until valid configuration arrives.
// - Resistive even channel makes adjacent odd channel config ignored.
// - Fault bit 0: converter communication error seen by analog processor.
// - Fault bit 1: communication with analog processor disrupted.
// - Fault bit 2: watchdog expired.
// - Fault bit 3: calibration data invalid.
// - Fault bit 4: firmware versions mismatch.
`timescale 1ns/1ps
`default_nettype none
`include "ais_defs.vh"

module ais_status_links
#(
  parameter PERIOD_CYCLES = `AIS_LINK_PERIOD_US * `AIS_CLK_MHZ
)
(
  input wire sys_clk,
  input wire resetn,
  // Acquisition results, one slot per channel
  input wire [`AIS_NUM_CH*32-1:0] acq_value,
  input wire [`AIS_NUM_CH*32-1:0] acq_current_ua,
  input wire [`AIS_NUM_CH-1:0] acq_done,
  input wire [`AIS_NUM_CH-1:0] acq_at_high,
  input wire [`AIS_NUM_CH-1:0] acq_at_low,
  input wire [`AIS_NUM_CH*`AIS_RANGE_W-1:0] cfg_range,
  input wire [`AIS_NUM_CH-1:0] cfg_invalid,
  // Card fault sources, asynchronous to this clock
  input wire adc_comm_error,
  input wire analog_cpu_lost,
  input wire software_timeout_fault,
  input wire cal_invalid,
  input wire fw_mismatch,
  // Outbound link stream
  output reg [31:0] outbound_link_word,
  output reg [3:0] outbound_link_index,
  output reg outbound_link_valid,
  output reg outbound_link_last,
  output reg [31:0] channel_condition_flags,
  output reg [31:0] card_fault_flags
);

  // ===========================================================
  // Channel state
  // Each channel keeps its own registers; these buses only gather them
  // Results sit packed, channel n at bits 32n and up
  localparam NIB = `AIS_FLAGS_PER_CH;
  wire [`AIS_NUM_CH*32-1:0] chan_result;
  wire [`AIS_NUM_CH-1:0] wire_break_flag;
  wire [`AIS_NUM_CH-1:0] over_range_flag;
  wire [`AIS_NUM_CH-1:0] below_range_flag;
  wire [`AIS_NUM_CH-1:0] invalid_setup_flag;
  wire [`AIS_NUM_CH-1:0] eff_invalid;
  wire [`AIS_NUM_CH-1:0] ignored;

  // Resistive 3/4-wire detect on an even channel
  function is_resistive;
    input [`AIS_RANGE_W-1:0] r;
    begin
      is_resistive = (r == `AIS_RANGE_RTD3) || (r == `AIS_RANGE_RTD4);
    end
  endfunction

  // Range code of one channel out of the packed setup bus
  function [`AIS_RANGE_W-1:0] range_of;
    input [`AIS_NUM_CH*`AIS_RANGE_W-1:0] bus;
    input integer ch;
    begin
      range_of = bus[ch*`AIS_RANGE_W +: `AIS_RANGE_W];
    end
  endfunction

  // ===========================================================
  // Per-channel result and condition flags
  genvar g;
  generate
    for (g = 0; g < `AIS_NUM_CH; g = g + 1)
    begin : gen_ch
      wire [`AIS_RANGE_W-1:0] rng;
      wire [31:0] cur;
      wire in_loop_range;
      wire cur_low;
      wire cur_high;
      reg [31:0] result;
      reg wire_break;
      reg over_range;
      reg below_range;
      reg invalid_setup;
      reg [31:0] next_result;
      reg next_wire_break;
      reg next_over_range;
      reg next_below_range;

      // Per-channel views of the packed buses
      assign rng = range_of(cfg_range, g);
      assign cur = acq_current_ua[g*32 +: 32];
      assign in_loop_range = (rng == `AIS_RANGE_4_20MA);
      assign cur_low = (cur < `AIS_OPEN_SET_UA);
      assign cur_high = (cur > `AIS_OPEN_CLR_UA);

      // Odd partner of a resistive even channel is ignored
      if (g % 2 == 1)
      begin : gen_odd
        assign ignored[g] = is_resistive(range_of(cfg_range, g - 1));
      end
      else
      begin : gen_even
        assign ignored[g] = 1'h0;
      end
      // A setup fault on an ignored channel is not reported
      assign eff_invalid[g] = cfg_invalid[g] & ~ignored[g];

      // Next result and flags; a disabled channel reads zero
      always @*
      begin
        next_result = result;
        next_wire_break = wire_break;
        next_over_range = over_range;
        next_below_range = below_range;
        if (eff_invalid[g] || ignored[g])
        begin
          next_result = `AIS_ZERO32;
          next_wire_break = 1'h0;
          next_over_range = 1'h0;
          next_below_range = 1'h0;
        end
        else
        begin
          if (acq_done[g])
          begin
            next_result = acq_value[g*32 +: 32];
            next_over_range = acq_at_high[g];
            next_below_range = acq_at_low[g];
          end
          // Wire break only in the 4-20 mA range, with hysteresis
          if (!in_loop_range)
            next_wire_break = 1'h0;
          else if (acq_done[g] && cur_low)
            next_wire_break = 1'h1;
          else if (acq_done[g] && cur_high)
            next_wire_break = 1'h0;
        end
      end

      // Channel result and flag registers
      always @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          result <= `AIS_ZERO32;
          wire_break <= 1'h0;
          over_range <= 1'h0;
          below_range <= 1'h0;
          invalid_setup <= 1'h0;
        end
        else
        begin
          result <= next_result;
          wire_break <= next_wire_break;
          over_range <= next_over_range;
          below_range <= next_below_range;
          invalid_setup <= eff_invalid[g];
        end
      end

      // Pack the channel into the shared buses
      assign chan_result[g*32 +: 32] = result;
      assign wire_break_flag[g] = wire_break;
      assign over_range_flag[g] = over_range;
      assign below_range_flag[g] = below_range;
      assign invalid_setup_flag[g] = invalid_setup;
    end
  endgenerate

  // ===========================================================
  // Fault input synchronisers
  reg [`AIS_FLT_USED-1:0] flt_meta;
  reg [`AIS_FLT_USED-1:0] flt_sync;
  wire [`AIS_FLT_USED-1:0] flt_raw;
  assign flt_raw = {fw_mismatch, cal_invalid, software_timeout_fault,
                    analog_cpu_lost, adc_comm_error};

  // Two-stage sync of card fault levels
  // Levels must stand one clock or more to be seen
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flt_meta <= {`AIS_FLT_USED{1'h0}};
      flt_sync <= {`AIS_FLT_USED{1'h0}};
    end
    else
    begin
      flt_meta <= flt_raw;
      flt_sync <= flt_meta;
    end
  end

  // ===========================================================
  // Status word assembly
  reg [31:0] next_cond;
  reg [31:0] next_fault;
  integer i;

  // Pack four flags per channel
  always @*
  begin
    next_cond = `AIS_ZERO32;
    // One nibble per channel, channel 0 lowest
    for (i = 0; i < `AIS_NUM_CH; i = i + 1)
    begin
      next_cond[NIB*i + `AIS_BIT_OPEN] = wire_break_flag[i];
      next_cond[NIB*i + `AIS_BIT_OVER] = over_range_flag[i];
      next_cond[NIB*i + `AIS_BIT_UNDER] = below_range_flag[i];
      next_cond[NIB*i + `AIS_BIT_BADCFG] = invalid_setup_flag[i];
    end
  end

  // Card fault word, unused bits held zero
  always @*
  begin
    next_fault = `AIS_ZERO32;
    next_fault[`AIS_FLT_ADC] = flt_sync[`AIS_FLT_ADC];
    next_fault[`AIS_FLT_COMMS] = flt_sync[`AIS_FLT_COMMS];
    next_fault[`AIS_FLT_WDOG] = flt_sync[`AIS_FLT_WDOG];
    next_fault[`AIS_FLT_CAL] = flt_sync[`AIS_FLT_CAL];
    next_fault[`AIS_FLT_FW] = flt_sync[`AIS_FLT_FW];
  end

  // Registered status words
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      channel_condition_flags <= `AIS_ZERO32;
      card_fault_flags <= `AIS_ZERO32;
    end
    else
    begin
      channel_condition_flags <= next_cond;
      card_fault_flags <= next_fault;
    end
  end

  // ===========================================================
  // Link period timer and sender
  localparam ST_IDLE = 2'h1;
  localparam ST_SEND = 2'h2;
  reg [1:0] state;
  reg [31:0] tick_cnt;
  reg [3:0] link_idx;
  reg [31:0] next_word;
  wire period_tick;
  wire last_slot;
  assign period_tick = (tick_cnt == PERIOD_CYCLES - 1);
  // Slot counter has reached the card fault word
  assign last_slot = (link_idx == `AIS_NUM_LINKS - 1);

  // Free-running 2 ms divider
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      tick_cnt <= `AIS_ZERO32;
    else if (period_tick)
      tick_cnt <= `AIS_ZERO32;
    else
      tick_cnt <= tick_cnt + 32'h00000001;
  end

  // Word selected for the current link slot
  // Words are read live; a result landing mid-burst goes out in that burst if its slot is still to come
  always @*
  begin
    if (link_idx == `AIS_LINK_COND)
      next_word = channel_condition_flags;
    else if (link_idx == `AIS_LINK_FAULT)
      next_word = card_fault_flags;
    else
      next_word = chan_result[link_idx[2:0]*32 +: 32];
  end

  // Send ten words in order each period
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      link_idx <= 4'h0;
      outbound_link_word <= `AIS_ZERO32;
      outbound_link_index <= 4'h0;
      outbound_link_valid <= 1'h0;
      outbound_link_last <= 1'h0;
    end
    else
    begin
      outbound_link_valid <= 1'h0;
      outbound_link_last <= 1'h0;
      case (state)
        ST_IDLE:
        begin
          link_idx <= 4'h0;
          if (period_tick)
            state <= ST_SEND;
        end
        ST_SEND:
        begin
          // One word per clock, the two status words last
          outbound_link_word <= next_word;
          outbound_link_index <= link_idx;
          outbound_link_valid <= 1'h1;
          if (last_slot)
          begin
            outbound_link_last <= 1'h1;
            state <= ST_IDLE;
          end
          else
            link_idx <= link_idx + 4'h1;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== ais_status_links_assertions.sv
// Assertion checker for the status link block
`timescale 1ns/1ps
`default_nettype none
// ===================================================
// Stream framing and status word checks
module ais_status_links_chk
#(
  parameter int PERIOD_CYCLES = 20
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] cfg_invalid,
  input wire logic software_timeout_fault,
  input wire logic [3:0] outbound_link_index,
  input wire logic outbound_link_valid,
  input wire logic outbound_link_last,
  input wire logic [31:0] channel_condition_flags,
  input wire logic [31:0] card_fault_flags
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic vld_q;
  int gap;
  // Cycles since the last burst started
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      vld_q <= 1'b0;
      gap <= 0;
    end
    else
    begin
      vld_q <= outbound_link_valid;
      if (outbound_link_valid && !vld_q)
        gap <= 1;
      else if (gap != 0)
        gap <= gap + 1;
    end
  property p_last;
    outbound_link_last |-> outbound_link_valid && outbound_link_index == 4'h9;
  endproperty
  a_last: assert property (p_last) else $error("last flag misplaced");
  property p_step;
    outbound_link_valid && !outbound_link_last |=> outbound_link_valid
      && outbound_link_index == $past(outbound_link_index) + 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("link order broken");
  property p_first;
    $rose(outbound_link_valid) |-> outbound_link_index == 4'h0;
  endproperty
  a_first: assert property (p_first) else $error("burst start wrong");
  property p_period;
    $rose(outbound_link_valid) && gap != 0 |-> gap == PERIOD_CYCLES;
  endproperty
  a_period: assert property (p_period) else $error("period wrong");
  property p_unused;
    card_fault_flags[31:5] == 27'h0000000;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");
  property p_bad;
    cfg_invalid[0] |-> ##2 channel_condition_flags[3];
  endproperty
  a_bad: assert property (p_bad) else $error("bad setup flag late");
  property p_wdog;
    software_timeout_fault [*4] |-> card_fault_flags[2];
  endproperty
  a_wdog: assert property (p_wdog) else $error("timeout flag late");
  property p_rst;
    $rose(resetn) |-> channel_condition_flags == 32'h0
      && card_fault_flags == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("status not clear");
  // Main scenarios reached
  c_burst: cover property (outbound_link_last);
  c_bad: cover property (channel_condition_flags[23]);
  c_wdog: cover property (card_fault_flags[2]);
endmodule
bind ais_status_links ais_status_links_chk #(.PERIOD_CYCLES(PERIOD_CYCLES)) u_chk
(
  .sys_clk(sys_clk), .resetn(resetn), .cfg_invalid(cfg_invalid),
  .software_timeout_fault(software_timeout_fault),
  .outbound_link_index(outbound_link_index),
  .outbound_link_valid(outbound_link_valid),
  .outbound_link_last(outbound_link_last),
  .channel_condition_flags(channel_condition_flags),
  .card_fault_flags(card_fault_flags)
);
`default_nettype wire

// ===== ais_host_port.sv
// Host backplane port model collecting the outbound links
`timescale 1ns/1ps
`default_nettype none
// ===================================================
// Link receiver
module ais_host_port
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic valid,
  input wire logic [3:0] index,
  input wire logic [31:0] word,
  input wire logic last,
  output logic [31:0] link [0:9],
  output int bursts,
  output logic order_err
);
  logic [3:0] want;
  // Store each word by slot and watch the slot order
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      link <= '{default: 32'h0};
      bursts <= 0;
      order_err <= 1'b0;
      want <= 4'h0;
    end
    else if (valid)
    begin
      link[index] <= word;
      if (index !== want)
        order_err <= 1'b1;
      want <= last ? 4'h0 : want + 4'h1;
      if (last)
        bursts <= bursts + 1;
    end
endmodule
`default_nettype wire

// ===== test_ais_status_links.sv
// Testbench for the status link block
`timescale 1ns/1ps
`default_nettype none
// ===================================================
// Stimulus and checks
module test_ais_status_links;
  logic sys_clk = 0, resetn = 0, vld, last, oerr;
  logic [255:0] val = 0, cur = 0;
  logic [7:0] done = 0, hi = 0, lo = 0, inv = 0;
  logic [23:0] rng = 0;
  logic [4:0] flt = 0;
  logic [31:0] word, cond, fault;
  logic [31:0] link [0:9];
  logic [3:0] idx;
  int bursts, n_errors = 0, tests_run = 0, cyc = 0;
  ais_status_links #(.PERIOD_CYCLES(20)) DUT (
    .sys_clk(sys_clk), .resetn(resetn), .acq_value(val),
    .acq_current_ua(cur), .acq_done(done), .acq_at_high(hi),
    .acq_at_low(lo), .cfg_range(rng), .cfg_invalid(inv),
    .adc_comm_error(flt[0]), .analog_cpu_lost(flt[1]),
    .software_timeout_fault(flt[2]), .cal_invalid(flt[3]),
    .fw_mismatch(flt[4]), .outbound_link_word(word),
    .outbound_link_index(idx), .outbound_link_valid(vld),
    .outbound_link_last(last), .channel_condition_flags(cond),
    .card_fault_flags(fault));
  ais_host_port host (.sys_clk(sys_clk), .resetn(resetn), .valid(vld),
    .index(idx), .word(word), .last(last), .link(link),
    .bursts(bursts), .order_err(oerr));
  initial forever #2.5 sys_clk = ~sys_clk;
  // Cut a hang short
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      end_sim;
    end
  end
  task end_sim;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Pulse acquisitions, then let two bursts go out
  task acq(input logic [7:0] m);
    @(posedge sys_clk) done <= m;
    @(posedge sys_clk) done <= 8'h00;
    repeat (50) @(posedge sys_clk);
  endtask
  initial
  begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    chk(cond, 32'h0);
    chk(fault, 32'h0);
    for (int n = 0; n < 8; n++)
      val[32*n +: 32] <= 32'h40000000 | n;
    rng[3 +: 3] <= 3'h1;
    cur[32 +: 32] <= 32'h000007cf;
    hi <= 8'h04;
    lo <= 8'h08;
    acq(8'hff);
    for (int n = 0; n < 8; n++)
      chk(link[n], 32'h40000000 | n);
    chk(cond, 32'h00004210);
    chk(link[8], 32'h00004210);
    cur[32 +: 32] <= 32'h00000bb8;
    hi <= 8'h00;
    lo <= 8'h00;
    acq(8'hff);
    chk(cond, 32'h00000010);
    cur[32 +: 32] <= 32'h00000bb9;
    acq(8'h02);
    chk(cond, 32'h0);
    rng[6 +: 3] <= 3'h2;
    rng[18 +: 3] <= 3'h3;
    inv <= 8'ha1;
    acq(8'hff);
    chk(cond, 32'h00800008);
    chk(link[0], 32'h0);
    chk(link[5], 32'h0);
    chk(link[3], 32'h0);
    chk(link[7], 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      flt <= 5'h01 << i;
      acq(8'h00);
      chk(fault, 32'h1 << i);
      chk(link[9], 32'h1 << i);
    end
    chk(oerr, 1'b0);
    chk(bursts != 0, 32'h1);
    end_sim;
  end
endmodule
`default_nettype wire
